// *** spipb_port.sv ***
/*
  Buffered synchronous serial port, master or slave, with APB registers,
  receive and transmit buffers, terminator matching and command start.
  Assumes all link pins come from outside the clock domain and that the
  link clock is well below a quarter of the 125 MHz system clock.
*/
// The register addresses and the APB slave port were left to the implementer.
`default_nettype none

module spipb_port #(
  parameter int unsigned RX_DEPTH = 8192,
  parameter int unsigned TX_DEPTH = 8192
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Serial link
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  input wire logic RECEIVE_SELECT_N_I,
  output logic TRANSMIT_SELECT_N_O,
  output logic BUFFER_BUSY_O,
  input wire logic HALT_TRANSMIT_I,
  // Events
  output logic TERM_EVT_O,
  output logic CMD_START_O
);

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam logic [16:0] HALF = 17'(spipb_pkg::HALF_NUM);

  // ==========================================================
  // Registers
  spipb_pkg::spipb_ctrl_t ctrl_r;
  logic [9:0] speed_r;
  logic [7:0] fill_r;
  logic [15:0] term_r;
  logic [7:0] rd_pend_r;
  logic st_term_r, st_cmd_r, st_ovf_r;
  logic [31:0] prdata_r;
  logic pslverr_r, rd_pop_ok_r;

  logic acc_cyc, wr_cyc, is_mst, is_slv;
  assign acc_cyc = PSEL_I & PENABLE_I;
  assign wr_cyc = acc_cyc & PWRITE_I;
  assign is_mst = ctrl_r.role == spipb_pkg::ROLE_MST;
  assign is_slv = ctrl_r.role == spipb_pkg::ROLE_SLV;

  // ==========================================================
  // Buffers
  logic [7:0] rx_mem [RX_DEPTH];
  logic [7:0] tx_mem [TX_DEPTH];
  logic [RAW:0] rx_wp_r, rx_rp_r, rx_cnt;
  logic [TAW:0] tx_wp_r, tx_rp_r, tx_cnt;
  logic rx_full, rx_empty, tx_full, tx_empty;
  logic rx_push, rx_pop, tx_push, tx_pop;
  logic [7:0] tx_push_data;

  assign rx_cnt = rx_wp_r - rx_rp_r;
  assign tx_cnt = tx_wp_r - tx_rp_r;
  assign rx_full = rx_cnt == (RAW + 1)'(RX_DEPTH);
  assign tx_full = tx_cnt == (TAW + 1)'(TX_DEPTH);
  assign rx_empty = rx_cnt == '0;
  assign tx_empty = tx_cnt == '0;

  // ==========================================================
  // Pin synchronisers
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2;
  logic rss_s1, rss_s2, halt_s1, halt_s2;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {sdi_s1, sdi_s2, halt_s1, halt_s2} <= 4'h0;
      {rss_s1, rss_s2} <= 2'h3;
    end else begin
      sck_s1 <= SCK_I;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= SDI_I;
      sdi_s2 <= sdi_s1;
      rss_s1 <= RECEIVE_SELECT_N_I;
      rss_s2 <= rss_s1;
      halt_s1 <= HALT_TRANSMIT_I;
      halt_s2 <= halt_s1;
    end
  end

  // ==========================================================
  // Master clock generator
  // Fractional accumulator keeps the mean rate exact for any kbit/s value
  logic m_act_r, sck_m_r, m_tog, m_go, halt_ok, want;
  logic [4:0] m_tgl_r;
  logic [16:0] acc_r, acc_nxt;
  logic tx_send_ok, loaded_r;
  assign acc_nxt = acc_r + 17'(speed_r);
  assign m_tog = m_act_r & (acc_nxt >= HALF);
  assign halt_ok = !(ctrl_r.halt_en & halt_s2);
  assign tx_send_ok = (ctrl_r.txm != spipb_pkg::TX_OFF) & !tx_empty;
  assign want = tx_send_ok | (rd_pend_r != 8'h00);
  assign m_go = is_mst & !m_act_r & halt_ok & want;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      m_act_r <= 1'b0;
      sck_m_r <= 1'b0;
      m_tgl_r <= 5'h00;
      acc_r <= 17'h00000;
    end else if (!m_act_r) begin
      acc_r <= 17'h00000;
      sck_m_r <= ctrl_r.edge_fall; // Idle level leads with the sample edge
      m_tgl_r <= 5'h00;
      m_act_r <= m_go;
    end else if (m_tog) begin
      acc_r <= acc_nxt - HALF;
      sck_m_r <= ~sck_m_r;
      m_tgl_r <= m_tgl_r + 5'h01;
      if (m_tgl_r == 5'h0F) begin
        m_act_r <= 1'b0;
      end
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ==========================================================
  // Bit engine
  logic rise, fall, sel_ok, link_en, samp, shft, slave_load, load_go;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r, tx_sh_r, rx_next, tx_byte_in;
  assign rise = is_mst ? (m_tog & !sck_m_r) : (is_slv & sck_s2 & !sck_s3);
  assign fall = is_mst ? (m_tog & sck_m_r) : (is_slv & !sck_s2 & sck_s3);
  assign sel_ok = !ctrl_r.rss_en | !rss_s2;
  assign link_en = is_mst ? m_act_r : (is_slv & sel_ok);
  assign samp = link_en & (ctrl_r.edge_fall ? fall : rise);
  assign shft = link_en & (ctrl_r.edge_fall ? rise : fall);
  assign slave_load = is_slv & sel_ok & !loaded_r & (bit_cnt_r == 3'h0);
  assign load_go = m_go | slave_load;
  assign rx_next = ctrl_r.rx_lsb ? {sdi_s2, rx_sh_r[7:1]}
                                 : {rx_sh_r[6:0], sdi_s2};
  assign tx_byte_in = tx_send_ok ? tx_mem[tx_rp_r[TAW-1:0]] : fill_r;
  assign tx_pop = load_go & tx_send_ok;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bit_cnt_r <= 3'h0;
      loaded_r <= 1'b0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
    end else if (load_go) begin
      tx_sh_r <= tx_byte_in;
      loaded_r <= 1'b1;
      bit_cnt_r <= 3'h0;
    end else if (!link_en) begin
      bit_cnt_r <= 3'h0;
      loaded_r <= 1'b0;
    end else if (samp) begin
      rx_sh_r <= rx_next;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        loaded_r <= 1'b0;
      end
    end else if (shft && bit_cnt_r != 3'h0) begin
      tx_sh_r <= ctrl_r.tx_lsb ? {1'b0, tx_sh_r[7:1]}
                               : {tx_sh_r[6:0], 1'b0};
    end
  end

  assign SDO_O = ctrl_r.tx_lsb ? tx_sh_r[0] : tx_sh_r[7];
  assign SDO_OE_O = is_mst | (is_slv & sel_ok);
  assign SCK_O = sck_m_r;
  assign SCK_OE_O = is_mst;
  assign TRANSMIT_SELECT_N_O = !(is_mst & ctrl_r.txsel_en & m_act_r);

  // ==========================================================
  // Byte commit and terminator matching
  logic commit_r, match, hit, store, rx_on, term_evt_r, cmd_r;
  logic [7:0] rx_byte_r, prev_r;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      commit_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end else begin
      commit_r <= samp & (bit_cnt_r == 3'h7);
      if (samp && bit_cnt_r == 3'h7) begin
        rx_byte_r <= rx_next;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prev_r <= 8'h00;
    end else if (commit_r) begin
      prev_r <= rx_byte_r;
    end
  end

  always_comb begin
    match = 1'b0;
    if (ctrl_r.rxm == spipb_pkg::RX_CMD) begin
      match = rx_byte_r == spipb_pkg::CHAR_CR;
    end else begin
      unique case (ctrl_r.term)
        spipb_pkg::TM_ALL: match = 1'b1;
        spipb_pkg::TM_CRLF: match = (prev_r == spipb_pkg::CHAR_CR) &&
                                    (rx_byte_r == spipb_pkg::CHAR_LF);
        spipb_pkg::TM_CR: match = rx_byte_r == spipb_pkg::CHAR_CR;
        spipb_pkg::TM_LF: match = rx_byte_r == spipb_pkg::CHAR_LF;
        spipb_pkg::TM_NUL: match = rx_byte_r == spipb_pkg::CHAR_NUL;
        spipb_pkg::TM_BYTE: match = rx_byte_r == term_r[7:0];
        spipb_pkg::TM_STR: match = (prev_r == term_r[15:8]) &&
                                   (rx_byte_r == term_r[7:0]);
        default: match = 1'b0;
      endcase
    end
  end

  assign rx_on = (ctrl_r.rxm == spipb_pkg::RX_ACT) |
                 (ctrl_r.rxm == spipb_pkg::RX_CMD);
  assign hit = commit_r & rx_on & match;
  // Only the byte that completes a match is removed
  assign store = commit_r & rx_on & !(hit & ctrl_r.strip_terminator);
  assign rx_push = store & !rx_full;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      term_evt_r <= 1'b0;
      cmd_r <= 1'b0;
    end else begin
      term_evt_r <= hit & (ctrl_r.rxm == spipb_pkg::RX_ACT);
      cmd_r <= hit & (ctrl_r.rxm == spipb_pkg::RX_CMD);
    end
  end
  assign TERM_EVT_O = term_evt_r;
  assign CMD_START_O = cmd_r;
  assign BUFFER_BUSY_O = ctrl_r.busy_en & (rx_full | !rx_on);

  // ==========================================================
  // Buffer pointers and storage
  logic tx_echo, tx_apb;
  assign tx_echo = store & (ctrl_r.txm == spipb_pkg::TX_ECHO) & !tx_full;
  assign tx_apb = wr_cyc & (PADDR_I == spipb_pkg::ADDR_TXDATA) &
                  (ctrl_r.txm == spipb_pkg::TX_ACT) & !tx_full;
  assign tx_push = tx_echo | tx_apb;
  assign tx_push_data = tx_echo ? rx_byte_r : PWDATA_I[7:0];
  assign rx_pop = acc_cyc & !PWRITE_I & rd_pop_ok_r &
                  (PADDR_I == spipb_pkg::ADDR_RXDATA);

  always_ff @(posedge CLK_SYS_I) begin
    if (rx_push) begin
      rx_mem[rx_wp_r[RAW-1:0]] <= rx_byte_r;
    end
    if (tx_push) begin
      tx_mem[tx_wp_r[TAW-1:0]] <= tx_push_data;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end else begin
      rx_wp_r <= rx_wp_r + (RAW + 1)'(rx_push);
      rx_rp_r <= rx_rp_r + (RAW + 1)'(rx_pop);
      tx_wp_r <= tx_wp_r + (TAW + 1)'(tx_push);
      tx_rp_r <= tx_rp_r + (TAW + 1)'(tx_pop);
    end
  end

  // ==========================================================
  // APB register writes
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r <= spipb_pkg::CTRL_RST;
      speed_r <= 10'(spipb_pkg::KBPS_DEF);
      fill_r <= spipb_pkg::FILL_RST;
      term_r <= spipb_pkg::TERM_RST;
    end else if (wr_cyc) begin
      unique case (PADDR_I)
        spipb_pkg::ADDR_CTRL: begin
          ctrl_r <= PWDATA_I;
          ctrl_r.rsvd <= 12'h000;
        end
        spipb_pkg::ADDR_SPEED: begin
          // Out of range values are clamped to the nearest limit
          if (PWDATA_I < spipb_pkg::KBPS_MIN) begin
            speed_r <= 10'(spipb_pkg::KBPS_MIN);
          end else if (PWDATA_I > spipb_pkg::KBPS_MAX) begin
            speed_r <= 10'(spipb_pkg::KBPS_MAX);
          end else begin
            speed_r <= PWDATA_I[9:0];
          end
        end
        spipb_pkg::ADDR_FILL: fill_r <= PWDATA_I[7:0];
        spipb_pkg::ADDR_TERM: term_r <= PWDATA_I[15:0];
        default: begin
        end
      endcase
    end
  end

  // Pending dummy reads; a new write replaces the remaining count
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rd_pend_r <= 8'h00;
    end else if (wr_cyc && PADDR_I == spipb_pkg::ADDR_MREAD) begin
      rd_pend_r <= PWDATA_I[7:0];
    end else if (m_go && !tx_send_ok) begin
      rd_pend_r <= rd_pend_r - 8'h01;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  logic w1c;
  assign w1c = wr_cyc & (PADDR_I == spipb_pkg::ADDR_STATUS);
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_term_r <= 1'b0;
      st_cmd_r <= 1'b0;
      st_ovf_r <= 1'b0;
    end else begin
      st_term_r <= term_evt_r | (st_term_r & !(w1c & PWDATA_I[0]));
      st_cmd_r <= cmd_r | (st_cmd_r & !(w1c & PWDATA_I[1]));
      st_ovf_r <= (store & rx_full) |
                  (st_ovf_r & !(w1c & PWDATA_I[7]));
    end
  end

  // ==========================================================
  // APB read data, latched in the setup cycle
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[spipb_pkg::ST_TERM] = st_term_r;
    status[spipb_pkg::ST_CMD] = st_cmd_r;
    status[spipb_pkg::ST_RX_EMPTY] = rx_empty;
    status[spipb_pkg::ST_RX_FULL] = rx_full;
    status[spipb_pkg::ST_TX_EMPTY] = tx_empty;
    status[spipb_pkg::ST_TX_FULL] = tx_full;
    status[spipb_pkg::ST_BUSY] = BUFFER_BUSY_O;
    status[spipb_pkg::ST_OVF] = st_ovf_r;
    status[spipb_pkg::ST_CNT +: 16] = 16'(rx_cnt);
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      rd_pop_ok_r <= 1'b0;
    end else if (PSEL_I && !PENABLE_I) begin
      pslverr_r <= 1'b0;
      rd_pop_ok_r <= !rx_empty;
      prdata_r <= 32'h0000_0000;
      unique case (PADDR_I)
        spipb_pkg::ADDR_CTRL: prdata_r <= ctrl_r;
        spipb_pkg::ADDR_SPEED: prdata_r <= 32'(speed_r);
        spipb_pkg::ADDR_FILL: prdata_r <= 32'(fill_r);
        spipb_pkg::ADDR_TERM: prdata_r <= 32'(term_r);
        spipb_pkg::ADDR_TXDATA: prdata_r <= 32'h0000_0000;
        spipb_pkg::ADDR_RXDATA:
          prdata_r <= rx_empty ? 32'h0000_0000
                               : 32'(rx_mem[rx_rp_r[RAW-1:0]]);
        spipb_pkg::ADDR_STATUS: prdata_r <= status;
        spipb_pkg::ADDR_MREAD: prdata_r <= 32'(rd_pend_r);
        default: pslverr_r <= 1'b1;
      endcase
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = pslverr_r & acc_cyc;

  // ==========================================================
  // Assertions
  logic first_r;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_last_sample;
    samp && bit_cnt_r == 3'h7;
  endsequence
  sequence s_committed;
    commit_r && rx_byte_r == $past(rx_next);
  endsequence

  property p_reset_defaults;
    first_r |-> !ctrl_r.edge_fall && !ctrl_r.rx_lsb && !ctrl_r.tx_lsb &&
      ctrl_r.role == spipb_pkg::ROLE_OFF && ctrl_r.rxm == spipb_pkg::RX_OFF &&
      speed_r == 10'd100 && !BUFFER_BUSY_O && TRANSMIT_SELECT_N_O;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Control defaults wrong after reset");

  property p_byte_commit;
    s_last_sample |=> s_committed;
  endproperty
  a_byte_commit: assert property (p_byte_commit)
    else $error("Byte not committed after eighth bit");

  property p_busy;
    ctrl_r.busy_en |-> BUFFER_BUSY_O == (rx_full || !rx_on);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy output does not follow buffer state");

  property p_busy_off;
    !ctrl_r.busy_en |-> !BUFFER_BUSY_O;
  endproperty
  a_busy_off: assert property (p_busy_off)
    else $error("Busy output driven while unused");

  property p_discard_full;
    commit_r && rx_on && rx_full && !rx_pop |=> rx_cnt == $past(rx_cnt)
      && st_ovf_r;
  endproperty
  a_discard_full: assert property (p_discard_full)
    else $error("Byte stored into a full buffer");

  property p_term_all;
    commit_r && ctrl_r.rxm == spipb_pkg::RX_ACT &&
      ctrl_r.term == spipb_pkg::TM_ALL |=> TERM_EVT_O ##1 st_term_r;
  endproperty
  a_term_all: assert property (p_term_all)
    else $error("No event for matched byte");

  property p_cmd_cr;
    commit_r && ctrl_r.rxm == spipb_pkg::RX_CMD |=>
      CMD_START_O == ($past(rx_byte_r) == 8'h0D) && !TERM_EVT_O;
  endproperty
  a_cmd_cr: assert property (p_cmd_cr)
    else $error("Command start not tied to carriage return");

  property p_halt;
    is_mst && ctrl_r.halt_en && halt_s2 && !m_act_r |=> !m_act_r;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Master started while halted");

  property p_tss;
    !TRANSMIT_SELECT_N_O |-> is_mst && ctrl_r.txsel_en && m_act_r;
  endproperty
  a_tss: assert property (p_tss)
    else $error("Transmit select asserted outside a master transfer");

  property p_realign;
    is_slv && ctrl_r.rss_en && rss_s2 |=> bit_cnt_r == 3'h0;
  endproperty
  a_realign: assert property (p_realign)
    else $error("Bit count not cleared by deselect");

  property p_fill;
    load_go && !tx_send_ok |=> tx_sh_r == $past(fill_r);
  endproperty
  a_fill: assert property (p_fill)
    else $error("Fill byte not loaded on empty buffer");

  property p_speed_range;
    speed_r >= 10'd20 && speed_r <= 10'd1000;
  endproperty
  a_speed_range: assert property (p_speed_range)
    else $error("Link rate outside its range");

  property p_no_role;
    ctrl_r.role == spipb_pkg::ROLE_OFF |-> !SDO_OE_O && !SCK_OE_O && !samp;
  endproperty
  a_no_role: assert property (p_no_role)
    else $error("Port active while disabled");

endmodule

`default_nettype wire

// *** spipb_pkg.sv ***
/*
  Constants, register map and carrier types of the buffered serial port.
  Assumes a 125 MHz system clock and an APB master with 32-bit data.
*/
`default_nettype none

package spipb_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned KBPS_MIN = 20;
  localparam int unsigned KBPS_MAX = 1000;
  localparam int unsigned KBPS_DEF = 100;
  // Phase accumulator modulus: one half bit period per wrap
  localparam int unsigned HALF_NUM = CLK_HZ / (2 * 1000);

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SPEED = 8'h04;
  localparam logic [7:0] ADDR_FILL = 8'h08;
  localparam logic [7:0] ADDR_TERM = 8'h0C;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MREAD = 8'h1C;

  // ==========================================================
  // Status bit positions
  localparam int unsigned ST_TERM = 0;
  localparam int unsigned ST_CMD = 1;
  localparam int unsigned ST_RX_EMPTY = 2;
  localparam int unsigned ST_RX_FULL = 3;
  localparam int unsigned ST_TX_EMPTY = 4;
  localparam int unsigned ST_TX_FULL = 5;
  localparam int unsigned ST_BUSY = 6;
  localparam int unsigned ST_OVF = 7;
  localparam int unsigned ST_CNT = 16;

  // ==========================================================
  // Characters and reset values
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_NUL = 8'h00;
  localparam logic [7:0] FILL_RST = 8'hFF;
  localparam logic [15:0] TERM_RST = 16'h0000;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    ROLE_OFF = 2'h0, ROLE_MST = 2'h1, ROLE_SLV = 2'h2
  } spipb_role_t;
  typedef enum logic [1:0] {
    RX_OFF = 2'h0, RX_ACT = 2'h1, RX_CMD = 2'h2
  } spipb_rxm_t;
  typedef enum logic [1:0] {
    TX_OFF = 2'h0, TX_ACT = 2'h1, TX_ECHO = 2'h2
  } spipb_txm_t;
  typedef enum logic [2:0] {
    TM_ALL = 3'h0, TM_CRLF = 3'h1, TM_CR = 3'h2, TM_LF = 3'h3,
    TM_NUL = 3'h4, TM_BYTE = 3'h5, TM_STR = 3'h6
  } spipb_term_t;
  typedef enum logic [2:0] {
    ENC_S = 3'h0, ENC_W = 3'h1, ENC_M = 3'h2,
    ENC_SR = 3'h3, ENC_WR = 3'h4, ENC_MR = 3'h5
  } spipb_enc_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic [2:0] enc;
    logic [2:0] term;
    logic strip_terminator;
    logic rss_en;
    logic txsel_en;
    logic halt_en;
    logic busy_en;
    logic tx_lsb;
    logic rx_lsb;
    logic [1:0] txm;
    logic [1:0] rxm;
    logic edge_fall;
    logic [1:0] role;
  } spipb_ctrl_t;

  localparam spipb_ctrl_t CTRL_RST = '0;

endpackage

`default_nettype wire

// *** spipb_host_model.sv ***
/*
  Host controller model: drives link clock, data and select toward the
  port in slave role and captures what the port shifts back.
  Assumes an 80 ns link period built from 5 system clocks per half.
*/
`default_nettype none

module spipb_host_model (
  // Link
  input wire logic clk,
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
    got = 8'h00;
  end
  // ==========================================================
  // One byte, sampled by the port on rising link clock
  task automatic xfer(input logic [7:0] b);
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (5) @(posedge clk);
      sck <= 1'b0;
      mosi <= b[i];
      repeat (4) @(posedge clk);
      got[i] = miso;
      @(posedge clk);
      sck <= 1'b1;
    end
    repeat (5) @(posedge clk);
    sck <= 1'b0;
    repeat (5) @(posedge clk);
    ss_n <= 1'b1;
    // Released line must not keep its last value
    mosi <= ~mosi;
    repeat (10) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// *** tb.sv ***
/*
  Self-checking bench of the buffered serial port in slave and master role.
  Assumes zero wait APB answers and the host model on the link.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, r;
  logic pready, perr, err, sck, mosi, ss_n, miso, busy, tev, cev;
  logic sck_o, sck_oe, sdo_oe, tss_n, halt = 1'b0;
  int mismatches = 0, num_checks = 0, n_term = 0, n_cmd = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    n_term <= n_term + tev;
    n_cmd <= n_cmd + cev;
  end
  spipb_port #(.RX_DEPTH(16), .TX_DEPTH(16)) uut (.CLK_SYS_I(clk),
    .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready),
    .PSLVERR_O(perr), .SCK_I(sck), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .SDI_I(mosi), .SDO_O(miso), .SDO_OE_O(sdo_oe),
    .RECEIVE_SELECT_N_I(ss_n), .TRANSMIT_SELECT_N_O(tss_n),
    .BUFFER_BUSY_O(busy), .HALT_TRANSMIT_I(halt),
    .TERM_EVT_O(tev), .CMD_START_O(cev));
  spipb_host_model host (.clk(clk), .sck(sck), .mosi(mosi), .ss_n(ss_n),
    .miso(miso));
  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      mismatches++;
      print_verdict();
    end
    r = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle cycle keeps two requests from landing in one time step
    @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    apb(1'b0, spipb_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, spipb_pkg::ADDR_SPEED, 32'h0);
    chk(r, 32'h64);
    apb(1'b0, spipb_pkg::ADDR_FILL, 32'h0);
    chk(r, 32'hFF);
    chk(busy, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_rx();
    apb(1'b1, spipb_pkg::ADDR_CTRL, 32'h200);
    chk(busy, 32'h1);
    apb(1'b1, spipb_pkg::ADDR_FILL, 32'h3C);
    apb(1'b1, spipb_pkg::ADDR_CTRL, 32'h922A);
    chk(busy, 32'h0);
    host.xfer(8'hA5);
    chk(host.got, 32'h3C);
    host.xfer(8'h0D);
    chk(n_term, 32'h1);
    chk(sdo_oe, 32'h0);
    apb(1'b0, spipb_pkg::ADDR_RXDATA, 32'h0);
    chk(r, 32'hA5);
    apb(1'b0, spipb_pkg::ADDR_RXDATA, 32'h0);
    chk(r, 32'h0D);
  endtask
  task automatic t_lsb();
    apb(1'b1, spipb_pkg::ADDR_CTRL, 32'h92AA);
    host.xfer(8'h01);
    apb(1'b0, spipb_pkg::ADDR_RXDATA, 32'h0);
    chk(r, 32'h80);
  endtask
  task automatic t_ovf();
    apb(1'b1, spipb_pkg::ADDR_CTRL, 32'h922A);
    for (int i = 0; i < 17; i++) host.xfer(8'(i + 32'h40));
    chk(busy, 32'h1);
    apb(1'b0, spipb_pkg::ADDR_STATUS, 32'h0);
    chk(r[7], 32'h1);
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, spipb_pkg::ADDR_RXDATA, 32'h0);
      chk(r, (i < 16) ? i + 32'h40 : 32'h0);
    end
  endtask
  task automatic t_cmd();
    apb(1'b1, spipb_pkg::ADDR_CTRL, 32'h1212);
    host.xfer(8'h0A);
    chk(n_cmd, 32'h0);
    host.xfer(8'h0D);
    chk(n_cmd, 32'h1);
  endtask
  // Master byte: halted first, then captured on each sample edge
  task automatic t_mst(input logic fe, input logic lsb,
      input logic [7:0] b, input logic [7:0] exp);
    int k, n, t0;
    logic prev, went;
    logic [7:0] cap;
    n = 0;
    went = 1'b0;
    cap = 8'h00;
    prev = fe;
    t0 = n_term;
    halt <= 1'b1;
    apb(1'b1, spipb_pkg::ADDR_SPEED, 32'h3E8);
    apb(1'b1, spipb_pkg::ADDR_CTRL, {20'h0, 3'h6, lsb, 5'h05, fe, 2'h1});
    chk(sck_oe, 32'h1);
    apb(1'b1, spipb_pkg::ADDR_TXDATA, {24'h0, b});
    repeat (40) @(posedge clk);
    chk(tss_n, 32'h1);
    chk(sck_o, {31'h0, fe});
    halt <= 1'b0;
    for (k = 0; k < 3000 && !(went && tss_n === 1'b1); k++) begin
      @(posedge clk);
      if (tss_n === 1'b0) went = 1'b1;
      if (sck_o === !fe && prev === fe) begin
        cap = {cap[6:0], miso};
        n++;
      end
      prev = sck_o;
    end
    if (k == 3000) begin
      mismatches++;
      print_verdict();
    end
    chk(went, 32'h1);
    chk(n, 32'h8);
    chk(cap, exp);
    chk(n_term - t0, 32'h1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_rx();
    t_lsb();
    t_ovf();
    t_cmd();
    t_mst(1'b0, 1'b0, 8'hA5, 8'hA5);
    t_mst(1'b1, 1'b1, 8'h0B, 8'hD0);
    print_verdict();
  end
endmodule

`default_nettype wire
